// ---- bench/pdr_dev_model.sv ----
`timescale 1ns/1ps
// ----
// device end of the link
// ----
module pdr_dev_model (
  input wire i_clk_sys,
  input wire i_send,
  input wire [48:0] i_frame,
  output reg o_valid = 1'b0,
  output reg [48:0] o_frame = 49'h0
);
  reg [3:0] cnt_q = 4'h0;
  // valid stands four cycles so the input filter sees it; stale fields are scrambled
  always @(posedge i_clk_sys) begin
    if (i_send) begin
      cnt_q <= 4'hC;
      o_frame <= i_frame;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end else begin
      o_frame <= ~o_frame;
    end
    o_valid <= i_send || cnt_q > 4'h9;
  end
endmodule

// ---- bench/pdr_port_ctrl_bench.sv ----
`timescale 1ns/1ps
// ----
// port control bench
// ----
module pdr_port_ctrl_bench;
  reg clk = 0, rst = 1, busy = 0, snd = 0, done = 0;
  reg [10:0] wr = 0;
  reg [31:0] val = 0, last = 0;
  reg [48:0] fr = 0;
  integer posts = 0, checks = 0, failures = 0, n, p;
  wire lv, act, ract, rreq, idle, irq, mv, nme, gie, go, ren, rdy;
  wire [48:0] lf;
  wire [31:0] md, log, sig, pis;
  wire [15:0] tf;
  wire [3:0] fl = {rreq, ract, act, mv};
  always #12.5 clk = ~clk;
  pdr_dev_model dev (.i_clk_sys(clk), .i_send(snd), .i_frame(fr), .o_valid(lv), .o_frame(lf));
  pdr_port_ctrl dut (.i_clk_sys(clk), .i_reset(rst), .i_native_mode_enable_wr(wr[0]),
    .i_native_mode_enable_val(val[0]), .i_controller_reset_request_wr(wr[1]),
    .i_global_irq_enable_wr(wr[2]), .i_global_irq_enable_val(val[0]),
    .i_command_engine_go_wr(wr[3]), .i_command_engine_go_val(val[0]),
    .i_receive_engine_enable_wr(wr[4]), .i_receive_engine_enable_val(val[0]),
    .i_port_irq_enable_wr(wr[5]), .i_port_irq_enable_val(val),
    .i_port_irq_status_clr(wr[6]), .i_port_irq_status_mask(val),
    .i_port_error_log_clr(wr[7]), .i_port_error_log_mask(val),
    .i_port_irq_event(wr[8] ? val : 32'h0000_0000),
    .i_port_error_event(wr[9] ? val : 32'h0000_0000), .i_cmd_xfer_busy(busy),
    .i_fatal_halt(wr[10]), .i_link_frame_valid(lv), .i_frame_data(lf[31:0]),
    .i_frame_is_sig(lf[48]), .i_frame_tfd(lf[47:32]), .o_frame_ready(rdy), .o_mem_wr_valid(mv),
    .o_mem_wr_data(md), .i_mem_wr_done(done), .o_native_mode_enable(nme),
    .o_controller_reset_request(rreq), .o_global_irq_enable(gie), .o_command_engine_go(go),
    .o_command_engine_active(act), .o_receive_engine_enable(ren), .o_receive_engine_active(ract),
    .o_port_idle(idle), .o_port_irq_status(pis), .o_port_error_log(log), .o_task_file(tf),
    .o_signature(sig), .o_irq(irq));
  // memory side: one done pulse per posted word, so each write counts once
  always @(posedge clk) begin
    done <= mv && !done;
    if (mv && !done) begin
      posts <= posts + 1;
      last <= md;
    end
  end
  task print_verdict;
    begin
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  task c(input [48:0] g, input [48:0] e);
    begin
      checks = checks + 1;
      if (g !== e) begin
        failures = failures + 1;
        $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask
  // one write pulse of kind k carrying v
  task w(input integer k, input [31:0] v);
    begin
      @(posedge clk);
      wr[k] <= 1'b1;
      val <= v;
      @(posedge clk);
      wr <= 11'h000;
      @(negedge clk);
    end
  endtask
  // bounded wait for a status flag; running out ends the run
  task wt(input integer k, input e);
    begin
      n = 0;
      while (fl[k] !== e && n < 40) begin
        @(negedge clk);
        n = n + 1;
      end
      c(fl[k], e);
      if (fl[k] !== e) print_verdict;
    end
  endtask
  task f(input [48:0] v);
    begin
      @(posedge clk);
      snd <= 1'b1;
      fr <= v;
      @(posedge clk);
      snd <= 1'b0;
      repeat (16) @(negedge clk);
    end
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst <= 0;
    @(negedge clk);
    c(idle, 1);
    c({tf, sig}, 48'h007F_FFFF_FFFF);
    w(0, 1);
    c(nme, 1);
    w(4, 1);
    c(ren, 1);
    wt(2, 1);
    c(idle, 0);
    f({1'b0, 16'h0050, 32'h1234_5678});
    c(last, 32'h1234_5678);
    c(posts, 1);
    w(6, 32'hFFFF_FFFF);
    w(5, 1);
    w(8, 1);
    @(negedge clk);
    c(irq, 0);
    w(6, 1);
    w(2, 1);
    c(gie, 1);
    w(8, 1);
    @(negedge clk);
    c(irq, 1);
    c(pis, 1);
    w(5, 0);
    @(negedge clk);
    c(irq, 0);
    w(9, 32'h0000_0020);
    c(log, 32'h0000_0020);
    w(7, 32'hFFFF_FFFF);
    c(log, 0);
    $display("test receive and interrupt done");
    f({1'b1, 16'h0050, 32'h5A5A_0000});
    c(tf, 16'h0050);
    w(3, 1);
    c(go, 1);
    wt(1, 1);
    @(posedge clk) busy <= 1;
    w(3, 0);
    repeat (4) @(negedge clk);
    c(act, 1);
    @(posedge clk) busy <= 0;
    wt(1, 0);
    w(3, 1);
    wt(1, 1);
    w(10, 1);
    p = posts;
    f({1'b0, 16'h0050, 32'h0BAD_0001});
    c(posts, p);
    w(3, 0);
    wt(1, 0);
    repeat (8) @(negedge clk);
    c(last, 32'h0BAD_0001);
    c(posts, p + 1);
    $display("test command engine done");
    w(4, 0);
    wt(2, 0);
    p = posts;
    f({1'b0, 16'h0050, 32'h0000_0003});
    c(posts, p);
    c(idle, 1);
    f({1'b0, 16'h0050, 32'h0000_0004});
    f({1'b0, 16'h0050, 32'h0000_0005});
    c(rdy, 0);
    f({1'b0, 16'h0050, 32'h0000_0006});
    w(4, 1);
    wt(2, 1);
    repeat (16) @(negedge clk);
    c(posts, p + 3);
    c(last, 32'h0000_0005);
    c(rdy, 1);
    $display("test receive hold done");
    w(4, 0);
    wt(2, 0);
    w(2, 0);
    c(gie, 0);
    w(0, 0);
    c(nme, 0);
    w(0, 1);
    w(4, 1);
    w(1, 1);
    wt(3, 0);
    c({nme, ren}, 0);
    f({1'b1, 16'h0040, 32'hA5A5_0001});
    c(sig, 32'hA5A5_0001);
    w(9, 32'h0400_0000);
    f({1'b1, 16'h0051, 32'hA5A5_0002});
    c(tf, 16'h0040);
    w(7, 32'h0400_0000);
    f({1'b1, 16'h0052, 32'hA5A5_0003});
    c(tf, 16'h0052);
    $display("test controller reset done");
    print_verdict;
  end
endmodule

// ---- bench/pdr_port_ctrl_props.sv ----
`timescale 1ns/1ps
// ----
// port control checker
// ----
module pdr_port_ctrl_props (
  input wire i_clk_sys,
  input wire i_reset,
  input wire i_cmd_xfer_busy,
  input wire o_command_engine_go,
  input wire o_command_engine_active,
  input wire o_receive_engine_enable,
  input wire o_receive_engine_active,
  input wire o_controller_reset_request,
  input wire o_global_irq_enable,
  input wire o_port_idle,
  input wire o_irq
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_reset);
  // short aliases keep each property on one line
  wire go = o_command_engine_go;
  wire act = o_command_engine_active;
  wire en = o_receive_engine_enable;
  wire ract = o_receive_engine_active;
  wire rreq = o_controller_reset_request;
  wire any_on = go | act | en | ract;
  a_go_starts_cmd: assert property ($rose(go) |=> act)
    else $error("command engine did not start");
  a_busy_keeps_cmd: assert property (act && i_cmd_xfer_busy && !rreq |=> act)
    else $error("command engine stopped mid transfer");
  a_idle_when_quiet: assert property (!any_on |=> o_port_idle)
    else $error("idle flag missing");
  a_rx_follows_on: assert property ($rose(en) |-> ##[1:8] ract)
    else $error("receive engine did not start");
  a_rx_follows_off: assert property ($fell(en) |-> ##[1:8] !ract)
    else $error("receive engine did not stop");
  a_irq_needs_global: assert property (!o_global_irq_enable |=> !o_irq)
    else $error("interrupt without global enable");
  a_reset_self_clear: assert property ($rose(rreq) |-> rreq [*8] ##1 rreq [*8] ##1 !rreq)
    else $error("reset request length wrong");
  a_reset_drops_rx: assert property ($rose(rreq) |-> ##[0:3] !en)
    else $error("reset kept receive enable");
  c_cmd_run: cover property ($fell(act));
  c_irq: cover property ($rose(o_irq));
  c_reset: cover property ($fell(rreq));
endmodule
bind pdr_port_ctrl pdr_port_ctrl_props chk (.*);

// ---- hdl/pdr_defs.vh ----
// Operation
// - idle means go, active, enable, receive-active zero
// - error log bits clear by writing ones
// - interrupt needs port and global enable
// - task file loads only while diag zero
// - receive enable raises active, frames copied
// - receive off holds frames, blocks when full; the code blocks once three of four words are held
// - controller reset clears enable, keeps signature
// - after fatal error withhold posting until go clears
// - reset request self-clears after internal reset
`ifndef PDR_DEFS_VH
`define PDR_DEFS_VH
`define PDR_FIFO_DEPTH 4
`define PDR_FIFO_AW 2
`define PDR_FRAME_W 32
`define PDR_ERR_W 32
`define PDR_IRQ_W 32
`define PDR_TFD_W 16
`define PDR_TFD_RST 16'h007F
`define PDR_HRST_CYC 8'h10
`define PDR_SIG_W 32
`define PDR_SIG_RST 32'hFFFF_FFFF
`define PDR_DIAG_X_BIT 26
`endif

// ---- hdl/pdr_port_ctrl.v ----
`timescale 1ns/1ps
`include "pdr_defs.vh"
module pdr_port_ctrl (
  input wire i_clk_sys,
  input wire i_reset,
  // software side controls
  input wire i_native_mode_enable_wr,
  input wire i_native_mode_enable_val,
  input wire i_controller_reset_request_wr,
  input wire i_global_irq_enable_wr,
  input wire i_global_irq_enable_val,
  input wire i_command_engine_go_wr,
  input wire i_command_engine_go_val,
  input wire i_receive_engine_enable_wr,
  input wire i_receive_engine_enable_val,
  input wire i_port_irq_enable_wr,
  input wire [31:0] i_port_irq_enable_val,
  input wire i_port_irq_status_clr,
  input wire [31:0] i_port_irq_status_mask,
  input wire i_port_error_log_clr,
  input wire [31:0] i_port_error_log_mask,
  // block events
  input wire [31:0] i_port_irq_event,
  input wire [31:0] i_port_error_event,
  input wire i_cmd_xfer_busy,
  input wire i_fatal_halt,
  // link side frame stream (from another clock domain source pins)
  input wire i_link_frame_valid,
  input wire [31:0] i_frame_data,
  input wire i_frame_is_sig,
  input wire [15:0] i_frame_tfd,
  output reg o_frame_ready,
  // memory write side
  output reg o_mem_wr_valid,
  output reg [31:0] o_mem_wr_data,
  input wire i_mem_wr_done,
  // status
  output reg o_native_mode_enable,
  output reg o_controller_reset_request,
  output reg o_global_irq_enable,
  output reg o_command_engine_go,
  output reg o_command_engine_active,
  output reg o_receive_engine_enable,
  output reg o_receive_engine_active,
  output reg o_port_idle,
  output reg [31:0] o_port_irq_status,
  output reg [31:0] o_port_error_log,
  output reg [15:0] o_task_file,
  output reg [31:0] o_signature,
  output reg o_irq
);
  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  localparam ST_IDLE = 1'b0;
  localparam ST_WRITE = 1'b1;
  reg [31:0] fifo_mem [0:`PDR_FIFO_DEPTH-1];
  reg [`PDR_FIFO_AW-1:0] wr_ptr_q;
  reg [`PDR_FIFO_AW-1:0] rd_ptr_q;
  reg [`PDR_FIFO_AW:0] count_q;
  reg wstate_q;
  reg [7:0] hrst_cnt_q;
  reg [31:0] irq_en_q;
  reg withhold_q;
  reg fifo_push;
  reg fifo_pop;
  reg frame_taken_q;
  wire link_valid;
  wire frame_take;
  wire fifo_full;
  wire fifo_empty;
  wire hrst;
  assign fifo_full = (count_q == `PDR_FIFO_DEPTH);
  assign fifo_empty = (count_q == 0);
  assign hrst = o_controller_reset_request;
  assign frame_take = link_valid && o_frame_ready && !frame_taken_q;

  // frame valid is a pin from the link side
  pdr_sync u_sync (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_async(i_link_frame_valid),
    .o_level(link_valid)
  );

  // one word per frame: the filtered valid stands for several cycles
  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      frame_taken_q <= 1'b0;
    end else if (!link_valid) begin
      frame_taken_q <= 1'b0;
    end else if (frame_take) begin
      frame_taken_q <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // global control and controller reset
  // ------------------------------------------------------------
  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_native_mode_enable <= 1'b0;
      o_controller_reset_request <= 1'b0;
      o_global_irq_enable <= 1'b0;
      hrst_cnt_q <= 8'h00;
    end else if (hrst) begin
      // internal reset runs a fixed count then the request self-clears
      o_native_mode_enable <= 1'b0;
      o_global_irq_enable <= 1'b0;
      hrst_cnt_q <= hrst_cnt_q + 8'h01;
      if (hrst_cnt_q == `PDR_HRST_CYC - 8'h01) begin
        o_controller_reset_request <= 1'b0;
        hrst_cnt_q <= 8'h00;
      end
    end else begin
      if (i_native_mode_enable_wr) begin
        o_native_mode_enable <= i_native_mode_enable_val;
      end
      if (i_global_irq_enable_wr) begin
        o_global_irq_enable <= i_global_irq_enable_val;
      end
      // any write to the request sets it; there is no value to write
      if (i_controller_reset_request_wr) begin
        o_controller_reset_request <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // engine enables and command engine active
  // ------------------------------------------------------------
  always @(posedge i_clk_sys) begin
    if (i_reset || hrst) begin
      o_command_engine_go <= 1'b0;
      o_command_engine_active <= 1'b0;
      o_receive_engine_enable <= 1'b0;
      withhold_q <= 1'b0;
    end else begin
      if (i_command_engine_go_wr) begin
        o_command_engine_go <= i_command_engine_go_val;
      end
      if (i_receive_engine_enable_wr) begin
        o_receive_engine_enable <= i_receive_engine_enable_val;
      end
      // active rises with go; outside controller reset falls only once go clears and transfer has drained
      if (o_command_engine_go) begin
        o_command_engine_active <= 1'b1;
      end else if (!i_cmd_xfer_busy) begin
        o_command_engine_active <= 1'b0;
      end
      // fatal halt withholds posting until go is cleared
      if (i_fatal_halt) begin
        withhold_q <= 1'b1;
      end else if (!o_command_engine_go) begin
        withhold_q <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // receive fifo: holds frames while posting is off
  // ------------------------------------------------------------
  always @* begin
    fifo_push = frame_take && !i_frame_is_sig;
    fifo_pop = (wstate_q == ST_IDLE) && !fifo_empty && o_receive_engine_active && !withhold_q;
  end

  always @(posedge i_clk_sys) begin
    if (fifo_push) begin
      fifo_mem[wr_ptr_q] <= i_frame_data;
    end
  end

  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      wr_ptr_q <= {`PDR_FIFO_AW{1'b0}};
      rd_ptr_q <= {`PDR_FIFO_AW{1'b0}};
      count_q <= {(`PDR_FIFO_AW+1){1'b0}};
      o_frame_ready <= 1'b0;
    end else begin
      if (fifo_push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (fifo_pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      if (fifo_push && !fifo_pop) begin
        count_q <= count_q + 1'b1;
      end else if (fifo_pop && !fifo_push) begin
        count_q <= count_q - 1'b1;
      end
      // reception blocked once three words held; the spare slot covers push latency
      o_frame_ready <= (count_q < `PDR_FIFO_DEPTH - 1) && !fifo_full;
    end
  end

  // ------------------------------------------------------------
  // memory write engine and receive active handshake
  // ------------------------------------------------------------
  always @(posedge i_clk_sys) begin
    if (i_reset || hrst) begin
      wstate_q <= ST_IDLE;
      o_mem_wr_valid <= 1'b0;
      o_mem_wr_data <= 32'h0000_0000;
      o_receive_engine_active <= 1'b0;
    end else begin
      case (wstate_q)
        ST_IDLE: begin
          // outside controller reset, active only changes between frame writes
          o_receive_engine_active <= o_receive_engine_enable;
          if (fifo_pop) begin
            o_mem_wr_valid <= 1'b1;
            o_mem_wr_data <= fifo_mem[rd_ptr_q];
            wstate_q <= ST_WRITE;
          end
        end
        default: begin
          if (i_mem_wr_done) begin
            o_mem_wr_valid <= 1'b0;
            wstate_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // task file and signature
  // ------------------------------------------------------------
  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_task_file <= `PDR_TFD_RST;
      o_signature <= `PDR_SIG_RST;
    end else if (frame_take && i_frame_is_sig) begin
      // signature frame accepted even with receive disabled
      o_signature <= i_frame_data;
      if (!o_port_error_log[`PDR_DIAG_X_BIT]) begin
        o_task_file <= i_frame_tfd;
      end
    end
  end

  // ------------------------------------------------------------
  // error log, irq status, irq enable; set wins over clear
  // ------------------------------------------------------------
  always @(posedge i_clk_sys) begin
    if (i_reset || hrst) begin
      o_port_error_log <= 32'h0000_0000;
      o_port_irq_status <= 32'h0000_0000;
      irq_en_q <= 32'h0000_0000;
    end else begin
      o_port_error_log <= (o_port_error_log &
        ~({32{i_port_error_log_clr}} & i_port_error_log_mask)) |
        i_port_error_event;
      o_port_irq_status <= (o_port_irq_status &
        ~({32{i_port_irq_status_clr}} & i_port_irq_status_mask)) | i_port_irq_event;
      if (i_port_irq_enable_wr) begin
        irq_en_q <= i_port_irq_enable_val;
      end
    end
  end

  // ------------------------------------------------------------
  // outputs: interrupt and idle
  // ------------------------------------------------------------
  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_irq <= 1'b0;
      o_port_idle <= 1'b1;
    end else begin
      o_irq <= o_global_irq_enable && |(o_port_irq_status & irq_en_q);
      o_port_idle <= !o_command_engine_go && !o_command_engine_active &&
        !o_receive_engine_enable && !o_receive_engine_active;
    end
  end
endmodule

// ---- hdl/pdr_sync.v ----
`timescale 1ns/1ps
// three-stage synchroniser; change accepted when stages two and three agree
module pdr_sync (
  input wire i_clk_sys,
  input wire i_reset,
  input wire i_async,
  output reg o_level
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  // ------------------------------------------------------------
  // sampling chain
  // ------------------------------------------------------------
  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      o_level <= 1'b0;
    end else begin
      s1_q <= i_async;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        o_level <= s3_q; // filters one-cycle disagreement
      end
    end
  end
endmodule
